// file: hdl/hfac_host.sv
// Host controller driving the half-flash converter through its pins
`timescale 1ns/100ps
`include "hfac_regs.svh"

module hfac_host (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// User side
	input  wire logic       start,
	input  wire logic [2:0] chan,
	input  wire logic       mode_wrrd,
	input  wire logic       sleep_req,
	output logic            busy,
	output logic            done,
	output logic [7:0]      result,
	output logic            timeout,
	// Device pins
	output logic            mode_sel,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n_o,
	output logic            wr_n_oe_n,
	input  wire logic       wr_rdy_i,
	input  wire logic       int_n,
	input  wire logic [7:0] data_i,
	output logic            channel_addr_lsb,
	output logic            channel_addr_mid,
	output logic            channel_addr_msb,
	output logic            sleep_n
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic       int_s1_r,  int_s2_r;
	logic       rdy_s1_r,  rdy_s2_r;
	logic [7:0] dat_s1_r,  dat_s2_r;

	// Asynchronous pins pass two flops before use
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			int_s1_r <= 1'b1;
			int_s2_r <= 1'b1;
			rdy_s1_r <= 1'b1;
			rdy_s2_r <= 1'b1;
			dat_s1_r <= 8'h00;
			dat_s2_r <= 8'h00;
		end else begin
			int_s1_r <= int_n;
			int_s2_r <= int_s1_r;
			rdy_s1_r <= wr_rdy_i;
			rdy_s2_r <= rdy_s1_r;
			dat_s1_r <= data_i;
			dat_s2_r <= dat_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	hfac_pkg::hfac_state_t     st_r, st_nxt;
	logic [`HFAC_CNT_W-1:0]    cnt_r, cnt_nxt;
	logic                      md_r, md_nxt;
	logic [2:0]                ch_r, ch_nxt;
	logic                      cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
	logic                      busy_r, busy_nxt, done_r, done_nxt, tmo_r, tmo_nxt;
	logic [7:0]                res_r, res_nxt;
	logic                      slp_n_r, slp_n_nxt;
	logic                      conv_end;

	// End of conversion: interrupt low, and in read mode ready back high as well
	assign conv_end = md_r ? !int_s2_r : (rdy_s2_r && !int_s2_r);

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		md_nxt    = md_r;
		ch_nxt    = ch_r;
		cs_n_nxt  = cs_n_r;
		rd_n_nxt  = rd_n_r;
		wr_n_nxt  = wr_n_r;
		busy_nxt  = busy_r;
		done_nxt  = 1'b0;
		tmo_nxt   = 1'b0;
		res_nxt   = res_r;
		slp_n_nxt = slp_n_r;
		case (st_r)
			hfac_pkg::HFAC_SLEEP: begin
				cs_n_nxt = 1'b1;
				rd_n_nxt = 1'b1;
				wr_n_nxt = 1'b1;
				if (!sleep_req) begin
					slp_n_nxt = 1'b1;
					cnt_nxt   = `HFAC_CNT_W'(`HFAC_WAKE_CYC);
					st_nxt    = hfac_pkg::HFAC_WAKE;
				end
			end
			hfac_pkg::HFAC_WAKE: begin
				if (cnt_r != '0)
					cnt_nxt = cnt_r - `HFAC_CNT_W'(1);
				else
					st_nxt = hfac_pkg::HFAC_IDLE;
			end
			hfac_pkg::HFAC_IDLE: begin
				busy_nxt = 1'b0;
				if (sleep_req) begin
					// enter shutdown; sequencing restarts from idle
					slp_n_nxt = 1'b0;
					st_nxt    = hfac_pkg::HFAC_SLEEP;
				end else if (start) begin
					// address set, then held through acquisition
					ch_nxt   = chan;
					md_nxt   = mode_wrrd;
					busy_nxt = 1'b1;
					cnt_nxt  = `HFAC_CNT_W'(`HFAC_ACQ_CYC);
					st_nxt   = hfac_pkg::HFAC_ACQ;
				end
			end
			hfac_pkg::HFAC_ACQ: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - `HFAC_CNT_W'(1);
				end else begin
					cs_n_nxt = 1'b0;
					if (md_r) begin
						wr_n_nxt = 1'b0;
						cnt_nxt  = `HFAC_CNT_W'(`HFAC_WR_CYC);
						st_nxt   = hfac_pkg::HFAC_WRLO;
					end else begin
						// read strobe low starts read-mode conversion
						rd_n_nxt = 1'b0;
						cnt_nxt  = `HFAC_CNT_W'(`HFAC_CONV_TMO_CYC);
						st_nxt   = hfac_pkg::HFAC_WAIT;
					end
				end
			end
			hfac_pkg::HFAC_WRLO: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - `HFAC_CNT_W'(1);
				end else begin
					wr_n_nxt = 1'b1;
					cnt_nxt  = `HFAC_CNT_W'(`HFAC_CONV_TMO_CYC);
					st_nxt   = hfac_pkg::HFAC_WAIT;
				end
			end
			hfac_pkg::HFAC_WAIT: begin
				// wait for interrupt low, bounded by a timeout
				if (conv_end) begin
					rd_n_nxt = 1'b0;
					cnt_nxt  = `HFAC_CNT_W'(`HFAC_RD_HOLD_CYC);
					st_nxt   = hfac_pkg::HFAC_READ;
				end else if (cnt_r == '0) begin
					tmo_nxt  = 1'b1;
					cs_n_nxt = 1'b1;
					rd_n_nxt = 1'b1;
					st_nxt   = hfac_pkg::HFAC_IDLE;
				end else begin
					cnt_nxt = cnt_r - `HFAC_CNT_W'(1);
				end
			end
			hfac_pkg::HFAC_READ: begin
				// Data passes two sync flops, so hold read low long enough
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - `HFAC_CNT_W'(1);
				end else begin
					// bit order kept, latched until next result
					res_nxt  = dat_s2_r;
					done_nxt = 1'b1;
					// rising select and read clear the interrupt
					cs_n_nxt = 1'b1;
					rd_n_nxt = 1'b1;
					st_nxt   = hfac_pkg::HFAC_IDLE;
				end
			end
			default: st_nxt = hfac_pkg::HFAC_IDLE;
		endcase
	end

	// Registered state; device is awake and idle after reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_r    <= hfac_pkg::HFAC_IDLE;
			cnt_r   <= '0;
			md_r    <= `HFAC_MODE_READ;
			ch_r    <= 3'h0;
			cs_n_r  <= 1'b1;
			rd_n_r  <= 1'b1;
			wr_n_r  <= 1'b1;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			tmo_r   <= 1'b0;
			res_r   <= 8'h00;
			slp_n_r <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			md_r    <= md_nxt;
			ch_r    <= ch_nxt;
			cs_n_r  <= cs_n_nxt;
			rd_n_r  <= rd_n_nxt;
			wr_n_r  <= wr_n_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
			tmo_r   <= tmo_nxt;
			res_r   <= res_nxt;
			slp_n_r <= slp_n_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// mode always driven; shared pin driven only in write-read
	assign mode_sel         = md_r;
	assign wr_n_o           = wr_n_r;
	assign wr_n_oe_n        = ~md_r;
	assign cs_n             = cs_n_r;
	assign rd_n             = rd_n_r;
	// channel 7 selects the reference check channel
	assign channel_addr_lsb = ch_r[0];
	assign channel_addr_mid = ch_r[1];
	assign channel_addr_msb = ch_r[2];
	assign sleep_n          = slp_n_r;
	assign busy             = busy_r;
	assign done             = done_r;
	assign result           = res_r;
	assign timeout          = tmo_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence wake_hold_s;
		$rose(slp_n_r) ##1 (cs_n_r [*8]);
	endsequence

	wake_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wake_hold_s |-> ##1 cs_n_r) else $error("Select fell before wake time");
	strobe_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!rd_n_r || !wr_n_r) |-> !cs_n_r) else $error("Strobe without select");
	acq_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(cs_n_r) |-> (ch_r == $past(ch_r, 8)) && $past(busy_r, 8)) else $error("Address not settled");
	wr_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(wr_n_r) |-> !wr_n_r [*8] ##1 !wr_n_r [*2]) else $error("Write pulse too short");
	rd_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		done_r |-> cs_n_r && rd_n_r) else $error("Interrupt not cleared after read");
	sleep_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!slp_n_r |-> cs_n_r && rd_n_r && wr_n_r) else $error("Strobe during shutdown");
	mode_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!wr_n_r |-> md_r && !wr_n_oe_n) else $error("Write strobe in read mode");
	result_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!done_r |=> (result == $past(res_r)) || done_r) else $error("Result changed without done");

endmodule : hfac_host

// file: hdl/hfac_regs.svh
// Timing counts and field constants for the half-flash converter host controller
`ifndef HFAC_REGS_SVH
`define HFAC_REGS_SVH

// ----------------------------------------------------------------
// Pin levels
// ----------------------------------------------------------------
`define HFAC_MODE_READ        1'b0
`define HFAC_MODE_WRRD        1'b1
`define HFAC_REF_CHANNEL      3'h7

// ----------------------------------------------------------------
// Times in ns and derived cycle counts at 40 ns per cycle
// ----------------------------------------------------------------
`define HFAC_CLK_PERIOD_NS    40
`define HFAC_WAKE_NS          360
`define HFAC_WAKE_CYC         ((`HFAC_WAKE_NS + `HFAC_CLK_PERIOD_NS - 1) / `HFAC_CLK_PERIOD_NS)
`define HFAC_ACQ_NS           260
`define HFAC_ACQ_CYC          ((`HFAC_ACQ_NS + `HFAC_CLK_PERIOD_NS - 1) / `HFAC_CLK_PERIOD_NS)
`define HFAC_WR_NS            400
`define HFAC_WR_CYC           ((`HFAC_WR_NS + `HFAC_CLK_PERIOD_NS - 1) / `HFAC_CLK_PERIOD_NS)
`define HFAC_CONV_TMO_NS      2000
`define HFAC_CONV_TMO_CYC     (`HFAC_CONV_TMO_NS / `HFAC_CLK_PERIOD_NS)
// Read strobe held this many extra cycles so data clears the two sync flops
`define HFAC_RD_HOLD_CYC      2
`define HFAC_CNT_W            6

`endif

// file: hdl/hfac_pkg.sv
// Types for the half-flash converter host controller
package hfac_pkg;

	// ----------------------------------------------------------------
	// Sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		HFAC_SLEEP = 7'b000_0001,
		HFAC_WAKE  = 7'b000_0010,
		HFAC_IDLE  = 7'b000_0100,
		HFAC_ACQ   = 7'b000_1000,
		HFAC_WRLO  = 7'b001_0000,
		HFAC_WAIT  = 7'b010_0000,
		HFAC_READ  = 7'b100_0000
	} hfac_state_t;

endpackage : hfac_pkg

// file: verif/hfac_dev_model.sv
// Pin-level behavioural model of the half-flash converter
`timescale 1ns/100ps
module hfac_dev_model #(
	parameter int ACQ_NS  = 260,
	parameter int WAKE_NS = 360
) (
	input  wire logic       mode_sel,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_pin,
	input  wire logic [2:0] addr,
	input  wire logic       sleep_n,
	output logic            int_n,
	output logic            rdy_low,
	output logic [7:0]      data
);
	logic [7:0] latch_r = 8'h00;
	logic [7:0] val;
	int         conv_ns = 700;
	int         gen = 0;
	int         bad_starts = 0;
	realtime    wake_t = 0;
	realtime    addr_t = 0;
	wire        wrrd;
	assign wrrd = (mode_sel === 1'b1);
	assign val = (addr == 3'h7) ? 8'hFF : {addr, 5'h0A};
	// inverse of last value while released
	assign data = (!cs_n && !rd_n) ? latch_r : ~latch_r;
	initial begin
		int_n = 1'b1;
		rdy_low = 1'b0;
	end
	// early starts are counted for the bench
	task automatic note_start();
		if (($realtime - wake_t) < WAKE_NS || ($realtime - addr_t) < ACQ_NS)
			bad_starts++;
		gen++;
		int_n = 1'b1;
	endtask : note_start
	// Time stamps for settle checks
	always @(addr) addr_t = $realtime;
	always @(posedge sleep_n) wake_t = $realtime;
	// shutdown drops any conversion in flight
	always @(negedge sleep_n) begin
		gen++;
		rdy_low = 1'b0;
	end
	// read mode conversion, ready held low meanwhile
	always @(negedge cs_n or negedge rd_n) begin
		if (sleep_n && !wrrd && !cs_n && !rd_n) begin
			automatic int g;
			note_start();
			g = gen;
			rdy_low = 1'b1;
			#(conv_ns);
			if (g == gen) begin
				latch_r = val;
				int_n = 1'b0;
				rdy_low = 1'b0;
			end
		end
	end
	// write strobe falling starts a conversion; select may fall in the same step
	always @(negedge wr_pin) begin
		#1;
		if (sleep_n && wrrd && !cs_n && !wr_pin)
			note_start();
	end
	// upper nibble on rising strobe, lower nibble later
	always @(posedge wr_pin) begin
		if (sleep_n && wrrd && !cs_n) begin
			automatic int g = gen;
			latch_r[7:4] = val[7:4];
			#(conv_ns / 2);
			if (g == gen) begin
				latch_r[3:0] = val[3:0];
				int_n = 1'b0;
			end
		end
	end
	// interrupt cleared by either strobe rising
	always @(posedge cs_n or posedge rd_n) int_n = 1'b1;
endmodule : hfac_dev_model

// file: verif/hfac_host_tb.sv
// Self-checking bench for the converter host controller
`timescale 1ns/100ps
module hfac_host_tb;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        start = 1'b0;
	logic [2:0]  chan = 3'h0;
	logic        mode_wrrd = 1'b0;
	logic        sleep_req = 1'b0;
	logic        busy, done, timeout, mode_sel, cs_n, rd_n, wr_n_o, wr_n_oe_n, int_n, rdy_low, sleep_n;
	logic        channel_addr_lsb, channel_addr_mid, channel_addr_msb, done_seen, tmo_seen;
	logic [7:0]  result, data;
	int          miscompares = 0;
	int          n_checks = 0;
	// Rows: mode, channel, expected result
	logic [11:0] rows [10] = '{12'h00A, 12'h92A, 12'h24A, 12'hB6A, 12'h48A, 12'hDAA, 12'h6CA, 12'hFFF,
		12'h80A, 12'h7FF};
	// Shared pin: host drive, else open collector with pull-up
	wire         wr_pin = !wr_n_oe_n ? wr_n_o : !rdy_low;
	// Clock, 40 ns period
	always #20 clk_sys = ~clk_sys;
	hfac_host hfac_host_i (.clk_sys, .rst_b, .start, .chan, .mode_wrrd, .sleep_req, .busy, .done, .result,
		.timeout, .mode_sel, .cs_n, .rd_n, .wr_n_o, .wr_n_oe_n, .wr_rdy_i(wr_pin), .int_n, .data_i(data),
		.channel_addr_lsb, .channel_addr_mid, .channel_addr_msb, .sleep_n);
	hfac_dev_model hfac_dev_model_i (.mode_sel, .cs_n, .rd_n, .wr_pin, .sleep_n, .int_n, .rdy_low, .data,
		.addr({channel_addr_msb, channel_addr_mid, channel_addr_lsb}));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic finish_test();
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Hold start until taken, then wait for done or timeout
	task automatic convert(input logic md, input logic [2:0] ch);
		int k;
		@(posedge clk_sys);
		start <= 1'b1;
		chan <= ch;
		mode_wrrd <= md;
		for (k = 0; k < 40 && busy !== 1'b1; k++)
			@(negedge clk_sys);
		@(posedge clk_sys);
		start <= 1'b0;
		for (k = 0; k < 200 && done !== 1'b1 && timeout !== 1'b1; k++)
			@(negedge clk_sys);
		done_seen = done;
		tmo_seen = timeout;
	endtask : convert
	// Watchdog, well beyond the expected run
	initial begin
		#400us;
		miscompares++;
		finish_test();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(negedge clk_sys);
		chk("sleep_n", 8'h01, {7'h0, sleep_n});
		chk("cs_n", 8'h01, {7'h0, cs_n});
		for (int i = 0; i < 10; i++) begin
			convert(rows[i][11], rows[i][10:8]);
			chk("done", 8'h01, {7'h0, done_seen});
			chk("result", rows[i][7:0], result);
		end
		repeat (10) @(negedge clk_sys);
		chk("held", 8'hFF, result);
		// Shutdown with a start pending: start must be refused
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		start <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("sleep_n", 8'h00, {7'h0, sleep_n});
		chk("busy", 8'h00, {7'h0, busy});
		@(posedge clk_sys);
		sleep_req <= 1'b0;
		convert(1'b0, 3'h5);
		chk("wake", 8'hAA, result);
		// Stalled converter: timeout leaves the last result in place
		hfac_dev_model_i.conv_ns = 5000;
		convert(1'b0, 3'h2);
		chk("timeout", 8'h01, {7'h0, tmo_seen});
		chk("kept", 8'hAA, result);
		repeat (150) @(posedge clk_sys);
		hfac_dev_model_i.conv_ns = 700;
		convert(1'b1, 3'h6);
		chk("recover", 8'hCA, result);
		// Reset after a write-read run: pins return to idle levels, then a conversion runs again
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(negedge clk_sys);
		chk("mode_sel", 8'h00, {7'h0, mode_sel});
		chk("rd_n", 8'h01, {7'h0, rd_n});
		chk("wr_n_oe_n", 8'h01, {7'h0, wr_n_oe_n});
		chk("reset", 8'h00, result);
		convert(1'b0, 3'h3);
		chk("rerun", 8'h6A, result);
		chk("early", 8'h00, hfac_dev_model_i.bad_starts[7:0]);
		finish_test();
	end
endmodule : hfac_host_tb
